// >>> design/mqp_params.svh
// How it works
// R1: Bits 31:20 of each pointer register read back the programmed queue base address.
// R2: Inbound post top pointer is host loaded, then the device advances it by four, wrapping.
// R3: Inbound post bottom pointer is loaded and kept by the host only.
// R4: Outbound free top pointer is host loaded, then the device advances it by four, wrapping.
// R5: Outbound free bottom pointer changes only through host writes.
// R6: Outbound post top pointer changes only through host writes.
// R7: Outbound post bottom pointer is host loaded, then the device advances it, wrapping.
// R8: Queue size code picks 256, 1K, 4K, 16K or 64K entries; others reserved.
// R9: With queue disable set, port writes are dropped and port reads return all ones.
// R10: With read option set, equal top and bottom makes a bottom read return all ones.
// R11: Reset clears all pointers; bits 1:0 read zero and ignore writes.
`ifndef MQP_PARAMS_SVH
`define MQP_PARAMS_SVH

// Register byte offsets on the APB
`define MQP_CTRL_OFFSET 12'h200
`define MQP_IN_POST_TOP_OFFSET 12'h20C
`define MQP_IN_POST_BOTTOM_OFFSET 12'h210
`define MQP_OUT_FREE_TOP_OFFSET 12'h214
`define MQP_OUT_FREE_BOTTOM_OFFSET 12'h218
`define MQP_OUT_POST_TOP_OFFSET 12'h21C
`define MQP_OUT_POST_BOTTOM_OFFSET 12'h220
`define MQP_STATUS_OFFSET 12'h224
`define MQP_IN_PORT_OFFSET 12'h040
`define MQP_OUT_PORT_OFFSET 12'h044

// Pointer slots: top is even, its bottom is the next odd slot
`define MQP_NUM_PTR 6
`define MQP_IDX_IN_POST_TOP 3'h0
`define MQP_IDX_IN_POST_BOTTOM 3'h1
`define MQP_IDX_OUT_FREE_TOP 3'h2
`define MQP_IDX_OUT_FREE_BOTTOM 3'h3
`define MQP_IDX_OUT_POST_TOP 3'h4
`define MQP_IDX_OUT_POST_BOTTOM 3'h5

// Field positions
`define MQP_BASE_MSB 31
`define MQP_BASE_LSB 20
`define MQP_PTR_MSB 19
`define MQP_PTR_LSB 2
`define MQP_SIZE_MSB 10
`define MQP_SIZE_LSB 8
`define MQP_RDOPT_BIT 1
`define MQP_DISABLE_BIT 0

// Reset values and fixed words
`define MQP_PTR_RESET 18'h00000
`define MQP_BASE_RESET 12'h000
`define MQP_SIZE_RESET 3'h0
`define MQP_ALL_ONES 32'hFFFFFFFF
`define MQP_ZERO_WORD 32'h00000000
`define MQP_PTR_STEP 18'h00001

// Queue size codes and entry index masks within pointer bits 19:2
`define MQP_SIZE_256 3'h0
`define MQP_SIZE_1K 3'h1
`define MQP_SIZE_4K 3'h2
`define MQP_SIZE_16K 3'h3
`define MQP_SIZE_64K 3'h4
`define MQP_MASK_256 18'h000FF
`define MQP_MASK_1K 18'h003FF
`define MQP_MASK_4K 18'h00FFF
`define MQP_MASK_16K 18'h03FFF
`define MQP_MASK_64K 18'h0FFFF

`endif

// >>> design/mqp_pkg.sv
package mqp_pkg;
    // Entry pointer, register bits 19:2
    typedef logic [17:0] mqp_ptr_t;
    // Bus transfer sequencing
    typedef enum logic [1:0] {
        MQP_IDLE,
        MQP_MEM,
        MQP_RESP
    } mqp_state_t;
endpackage : mqp_pkg

// >>> design/mqp_ptr_reg.sv
`timescale 1ns/1ps
`include "mqp_params.svh"
module mqp_ptr_reg (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic load,
    input wire mqp_pkg::mqp_ptr_t loadValue,
    input wire logic advance,
    input wire logic [2:0] sizeCode,
    output mqp_pkg::mqp_ptr_t ptr,
    output mqp_pkg::mqp_ptr_t ptrAdvanced
);
    mqp_pkg::mqp_ptr_t wrapMask;
    mqp_pkg::mqp_ptr_t ptrPlusOne;
    mqp_pkg::mqp_ptr_t next_ptr;

    // Index width follows the size code; reserved codes fall back to the smallest queue
    assign wrapMask = (sizeCode == `MQP_SIZE_1K) ? `MQP_MASK_1K : // see R8
                      (sizeCode == `MQP_SIZE_4K) ? `MQP_MASK_4K :
                      (sizeCode == `MQP_SIZE_16K) ? `MQP_MASK_16K :
                      (sizeCode == `MQP_SIZE_64K) ? `MQP_MASK_64K : `MQP_MASK_256;

    // One entry is four bytes; upper bits keep the queue's slot in the region
    assign ptrPlusOne = ptr + `MQP_PTR_STEP;
    assign ptrAdvanced = (ptr & ~wrapMask) | (ptrPlusOne & wrapMask); // see R2

    // A host load wins over an advance, although the bus never issues both at once
    assign next_ptr = load ? loadValue : (advance ? ptrAdvanced : ptr);

    // Pointer storage
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ptr <= `MQP_PTR_RESET; // see R11
        end else begin
            ptr <= next_ptr;
        end
    end
endmodule : mqp_ptr_reg

// >>> design/mqp_apb_decode.sv
`timescale 1ns/1ps
`include "mqp_params.svh"
module mqp_apb_decode (
    input wire logic [11:0] paddr,
    output logic [5:0] ptrHit,
    output logic ctrlHit,
    output logic statusHit,
    output logic inPortHit,
    output logic outPortHit,
    output logic unmapped
);
    localparam logic [11:0] PTR_OFFSET [`MQP_NUM_PTR] = '{
        `MQP_IN_POST_TOP_OFFSET,
        `MQP_IN_POST_BOTTOM_OFFSET,
        `MQP_OUT_FREE_TOP_OFFSET,
        `MQP_OUT_FREE_BOTTOM_OFFSET,
        `MQP_OUT_POST_TOP_OFFSET,
        `MQP_OUT_POST_BOTTOM_OFFSET
    };

    // One comparator per pointer register; unaligned addresses match nothing
    genvar i;
    generate
        for (i = 0; i < `MQP_NUM_PTR; i = i + 1) begin : g_hit
            assign ptrHit[i] = (paddr == PTR_OFFSET[i]);
        end
    endgenerate

    // Remaining registers and the two queue ports
    assign ctrlHit = (paddr == `MQP_CTRL_OFFSET);
    assign statusHit = (paddr == `MQP_STATUS_OFFSET);
    assign inPortHit = (paddr == `MQP_IN_PORT_OFFSET);
    assign outPortHit = (paddr == `MQP_OUT_PORT_OFFSET);
    assign unmapped = ~((|ptrHit) | ctrlHit | statusHit | inPortHit | outPortHit);
endmodule : mqp_apb_decode

// >>> design/mqp_msg_queue_pointer_regs.sv
`timescale 1ns/1ps
`include "mqp_params.svh"
module mqp_msg_queue_pointer_regs (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic memReq,
    output logic memWrite,
    output logic [31:0] memAddr,
    output logic [31:0] memWrData,
    input wire logic [31:0] memRdData,
    input wire logic memAck,
    output logic [2:0] queueEmpty,
    output logic [2:0] queueFull
);
    // Control register fields
    logic [11:0] baseAddr;
    logic [2:0] sizeCode;
    logic queueDisable;
    logic bottomReadOption;

    // Bus sequencing
    mqp_pkg::mqp_state_t state;
    mqp_pkg::mqp_state_t next_state;
    logic [2:0] advSel;

    // Decoder outputs
    logic [5:0] ptrHit;
    logic ctrlHit;
    logic statusHit;
    logic inPortHit;
    logic outPortHit;
    logic unmapped;

    // Pointer bank
    mqp_pkg::mqp_ptr_t ptr [`MQP_NUM_PTR];
    mqp_pkg::mqp_ptr_t ptrAdvanced [`MQP_NUM_PTR];
    logic [5:0] ptrLoad;
    logic [5:0] ptrAdvance;
    logic [31:0] ptrWord [`MQP_NUM_PTR];
    logic [2:0] pairEqual;
    logic [2:0] pairFull;

    // Access qualifiers
    logic apbAccess;
    logic writeAccess;
    logic readAccess;
    logic inPost;
    logic outFree;
    logic outFetch;
    logic memStart;
    logic memDone;
    logic [2:0] startSel;
    logic [17:0] startPtr;
    logic [31:0] ctrlWord;
    logic [31:0] statusWord;
    logic [31:0] portRdData;
    logic [31:0] regRdData;
    logic [31:0] ptrRdData;

    mqp_apb_decode u_decode (
        .paddr(paddr),
        .ptrHit(ptrHit),
        .ctrlHit(ctrlHit),
        .statusHit(statusHit),
        .inPortHit(inPortHit),
        .outPortHit(outPortHit),
        .unmapped(unmapped)
    );

    // A request is acted on once, in the access phase while the slave is idle
    assign apbAccess = psel & penable & (state == mqp_pkg::MQP_IDLE);
    assign writeAccess = apbAccess & pwrite;
    assign readAccess = apbAccess & ~pwrite;
    assign memDone = (state == mqp_pkg::MQP_MEM) & memAck;

    // Port traffic while disabled completes normally but touches nothing
    assign inPost = writeAccess & inPortHit & ~queueDisable & ~pairFull[0]; // see R9
    assign outFree = writeAccess & outPortHit & ~queueDisable & ~pairFull[1]; // see R9
    assign outFetch = readAccess & outPortHit & ~queueDisable & ~pairEqual[2]; // see R9
    assign memStart = inPost | outFree | outFetch;

    // Which pointer a memory cycle uses and later advances
    assign startSel = inPost ? `MQP_IDX_IN_POST_TOP :
                      outFree ? `MQP_IDX_OUT_FREE_TOP : `MQP_IDX_OUT_POST_BOTTOM;
    assign startPtr = ptr[startSel];

    // Pointer registers, one per slot; the host writes bits 19:2 only
    genvar i;
    generate
        for (i = 0; i < `MQP_NUM_PTR; i = i + 1) begin : g_ptr
            assign ptrLoad[i] = writeAccess & ptrHit[i];
            mqp_ptr_reg u_ptr (
                .core_clk(core_clk),
                .reset(reset),
                .load(ptrLoad[i]),
                .loadValue(pwdata[`MQP_PTR_MSB:`MQP_PTR_LSB]), // see R11
                .advance(ptrAdvance[i]),
                .sizeCode(sizeCode),
                .ptr(ptr[i]),
                .ptrAdvanced(ptrAdvanced[i])
            );
            // Upper field mirrors the base, low two bits are always zero
            assign ptrWord[i] = {baseAddr, ptr[i], 2'h0}; // see R1
        end
    endgenerate

    // Only three slots are advanced by the device; the rest follow host writes alone
    assign ptrAdvance[0] = memDone & (advSel == `MQP_IDX_IN_POST_TOP); // see R2
    assign ptrAdvance[1] = 1'b0; // see R3
    assign ptrAdvance[2] = memDone & (advSel == `MQP_IDX_OUT_FREE_TOP); // see R4
    assign ptrAdvance[3] = 1'b0; // see R5
    assign ptrAdvance[4] = 1'b0; // see R6
    assign ptrAdvance[5] = memDone & (advSel == `MQP_IDX_OUT_POST_BOTTOM); // see R7

    // Per-queue empty and full; full leaves one slot unused so it differs from empty
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_pair
            assign pairEqual[i] = (ptr[2 * i] == ptr[2 * i + 1]);
            assign pairFull[i] = (ptrAdvanced[2 * i] == ptr[2 * i + 1]);
        end
    endgenerate
    assign queueEmpty = pairEqual;
    assign queueFull = pairFull;

    // Bottom reads of an empty queue may be forced to all ones
    assign ptrRdData =
        ptrHit[1] ? ((bottomReadOption & pairEqual[0]) ? `MQP_ALL_ONES : ptrWord[1]) : // see R10
        ptrHit[3] ? ((bottomReadOption & pairEqual[1]) ? `MQP_ALL_ONES : ptrWord[3]) : // see R10
        ptrHit[5] ? ((bottomReadOption & pairEqual[2]) ? `MQP_ALL_ONES : ptrWord[5]) : // see R10
        ptrHit[0] ? ptrWord[0] :
        ptrHit[2] ? ptrWord[2] :
        ptrHit[4] ? ptrWord[4] : `MQP_ZERO_WORD;

    // Control and status words; unused bits read as zero
    assign ctrlWord = {baseAddr, 9'h000, sizeCode, 6'h00, bottomReadOption, queueDisable};
    assign statusWord = {25'h0000000, pairFull, 1'b0, pairEqual};

    // Port reads that start no memory cycle: inbound has no source here, so all ones
    assign portRdData = `MQP_ALL_ONES; // see R9

    // Register read selection for reads that finish without memory
    assign regRdData = ctrlHit ? ctrlWord :
                       statusHit ? statusWord :
                       (inPortHit | outPortHit) ? portRdData :
                       (|ptrHit) ? ptrRdData : `MQP_ZERO_WORD;

    // Every transfer ends in the response state, so pready comes one cycle late, or one cycle after memAck when memory is used
    assign pready = (state == mqp_pkg::MQP_RESP);

    // Next bus state
    always_comb begin
        next_state = state;
        unique case (state)
            mqp_pkg::MQP_IDLE: begin
                if (apbAccess) begin
                    next_state = memStart ? mqp_pkg::MQP_MEM : mqp_pkg::MQP_RESP;
                end
            end
            mqp_pkg::MQP_MEM: begin
                if (memAck) begin
                    next_state = mqp_pkg::MQP_RESP;
                end
            end
            mqp_pkg::MQP_RESP: begin
                next_state = mqp_pkg::MQP_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= mqp_pkg::MQP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Control register; global reset clears every field
    always_ff @(posedge core_clk) begin
        if (reset) begin
            baseAddr <= `MQP_BASE_RESET;
            sizeCode <= `MQP_SIZE_RESET;
            queueDisable <= 1'b0;
            bottomReadOption <= 1'b0;
        end else if (writeAccess & ctrlHit) begin
            baseAddr <= pwdata[`MQP_BASE_MSB:`MQP_BASE_LSB]; // see R1
            sizeCode <= pwdata[`MQP_SIZE_MSB:`MQP_SIZE_LSB]; // see R8
            queueDisable <= pwdata[`MQP_DISABLE_BIT];
            bottomReadOption <= pwdata[`MQP_RDOPT_BIT];
        end
    end

    // Memory request: held from start until the acknowledge
    always_ff @(posedge core_clk) begin
        if (reset) begin
            memReq <= 1'b0;
            memWrite <= 1'b0;
            memAddr <= `MQP_ZERO_WORD;
            memWrData <= `MQP_ZERO_WORD;
            advSel <= `MQP_IDX_IN_POST_TOP;
        end else if (apbAccess & memStart) begin
            memReq <= 1'b1;
            memWrite <= pwrite;
            memAddr <= {baseAddr, startPtr, 2'h0};
            memWrData <= pwdata;
            advSel <= startSel;
        end else if (memDone) begin
            memReq <= 1'b0;
        end
    end

    // Read data and error; data is captured so it stays flat across the access
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prdata <= `MQP_ZERO_WORD;
            pslverr <= 1'b0;
        end else if (apbAccess & ~memStart) begin
            prdata <= pwrite ? `MQP_ZERO_WORD : regRdData;
            pslverr <= unmapped;
        end else if (apbAccess) begin
            prdata <= `MQP_ZERO_WORD;
            pslverr <= 1'b0;
        end else if (memDone) begin
            prdata <= memWrite ? `MQP_ZERO_WORD : memRdData;
        end
    end
endmodule : mqp_msg_queue_pointer_regs

// >>> testbench/mqp_checker_sva.sv
`timescale 1ns/1ps
module mqp_checker_sva (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic [31:0] memAddr,
    input wire logic memAck,
    input wire logic [2:0] queueEmpty,
    input wire logic [2:0] queueFull
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // Offsets that answer without an error
    function automatic logic mapped(input logic [11:0] a);
        return a inside {12'h200, 12'h20C, 12'h210, 12'h214, 12'h218, 12'h21C, 12'h220,
            12'h224, 12'h040, 12'h044};
    endfunction : mapped

    // Register access taken while idle; port offsets are left out since they may go to memory
    wire logic regTake = psel && penable && !pready && !memReq && paddr[11:8] == 4'h2
        && mapped(paddr);

    sequence memWait;
        memReq && !memAck;
    endsequence
    sequence memDone;
        memReq && memAck ##1 !memReq && pready;
    endsequence

    reg_answer_a: assert property (regTake |=> pready)
        else $error("register access not answered in one cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    err_map_a: assert property (pready |-> pslverr == !mapped(paddr))
        else $error("error flag does not match address map");
    err_zero_a: assert property (pready && (pslverr || pwrite) |-> prdata == 32'h00000000)
        else $error("read data not zero on write or error");
    mem_hold_a: assert property (memWait |=> memReq && $stable(memAddr) && $stable(memWrite))
        else $error("memory request changed before ack");
    mem_done_a: assert property (memReq && memAck |-> memDone)
        else $error("memory request not closed after ack");
    mem_align_a: assert property (memReq |-> memAddr[1:0] == 2'b00)
        else $error("memory address not word aligned");
    flag_excl_a: assert property ((queueEmpty & queueFull) == 3'b000)
        else $error("queue flagged empty and full at once");
    reset_state_a: assert property (@(posedge core_clk) disable iff (1'b0)
        $fell(reset) |-> queueEmpty == 3'b111 && queueFull == 3'b000 && !pready && !memReq)
        else $error("outputs not cleared by reset");
endmodule : mqp_checker_sva

bind mqp_msg_queue_pointer_regs mqp_checker_sva mqp_checker_sva_inst (.core_clk(core_clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .memReq(memReq),
    .memWrite(memWrite), .memAddr(memAddr), .memAck(memAck), .queueEmpty(queueEmpty),
    .queueFull(queueFull));

// >>> testbench/mqp_queue_mem.sv
`timescale 1ns/1ps
module mqp_queue_mem (
    input wire logic core_clk,
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic [31:0] memAddr,
    input wire logic [31:0] memWrData,
    input wire logic [1:0] lat,
    output logic [31:0] memRdData,
    output logic memAck
);
    logic [31:0] mem [logic [31:0]];
    logic [1:0] cnt;
    int nReq;

    initial begin
        memRdData = 32'h00000000;
        memAck = 1'b0;
        cnt = 2'h0;
        nReq = 0;
    end

    // Answer after lat wait cycles; data scrambles outside the ack cycle so stale reads show
    always @(posedge core_clk) begin
        memAck <= 1'b0;
        memRdData <= ~memRdData;
        if (memReq === 1'b1 && memAck !== 1'b1) begin
            if (cnt == lat) begin
                memAck <= 1'b1;
                cnt <= 2'h0;
                nReq <= nReq + 1;
                memRdData <= mem.exists(memAddr) ? mem[memAddr] : 32'h00000000;
                if (memWrite) mem[memAddr] = memWrData;
            end else cnt <= cnt + 2'h1;
        end
    end
endmodule : mqp_queue_mem

// >>> testbench/mqp_msg_queue_pointer_regs_bench.sv
`timescale 1ns/1ps
module mqp_msg_queue_pointer_regs_bench;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, memAddr, memWrData, memRdData, word, d1, d2;
    logic pready, pslverr, memReq, memWrite, memAck;
    logic [2:0] queueEmpty, queueFull;
    logic [1:0] lat = 2'h0;
    logic [32:0] expQ [$];
    logic [11:0] base;
    logic [17:0] mask, up;
    logic [11:0] ptrOff [6] = '{12'h20C, 12'h210, 12'h214, 12'h218, 12'h21C, 12'h220};
    int n_mismatch = 0, n_tests = 0, cycles = 0, seed = 14367, n0;

    initial forever #20 core_clk = ~core_clk;

    mqp_msg_queue_pointer_regs mqp_msg_queue_pointer_regs_inst (.core_clk(core_clk),
        .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr), .memWrData(memWrData),
        .memRdData(memRdData), .memAck(memAck), .queueEmpty(queueEmpty),
        .queueFull(queueFull));
    mqp_queue_mem mqp_queue_mem_inst (.core_clk(core_clk), .memReq(memReq),
        .memWrite(memWrite), .memAddr(memAddr), .memWrData(memWrData), .lat(lat),
        .memRdData(memRdData), .memAck(memAck));

    task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic test_done;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done

    // One APB transfer; the expected {error, data} is noted for the watcher
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [32:0] e);
        expQ.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 33'h000000000);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h00000000, {1'b0, e});
    endtask : rd

    // Watcher: every answer is matched against the oldest note; also cuts a hang short
    always @(posedge core_clk) begin
        cycles++;
        if (pready === 1'b1) begin
            if (expQ.size() == 0) chk("unexpected answer", 33'h000000000, 33'h1FFFFFFFF);
            else chk("apb answer", expQ.pop_front(), {pslverr, prdata});
        end
        if (cycles == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < 6; i++) rd(ptrOff[i], 32'h00000000);
        rd(12'h224, 32'h00000007);
        chk("empty flags", 33'h000000007, {30'h00000000, queueEmpty});
        chk("full flags", 33'h000000000, {30'h00000000, queueFull});
        xfer(1'b1, 12'h300, 32'hFFFFFFFF, 33'h100000000);
        xfer(1'b0, 12'h211, 32'h00000000, 33'h100000000);
        // Each of the five valid size codes; the device-advanced pointers start at the last entry so each advance wraps
        for (int c = 0; c < 5; c++) begin
            word = $random(seed);
            base = word[31:20];
            lat <= word[1:0];
            d1 = $random(seed);
            d2 = $random(seed);
            mask = (18'h00100 << (2 * c)) - 18'h00001;
            up = ~mask & 18'h30000;
            wr(12'h200, {base, 9'h000, c[2:0], 8'h00});
            for (int q = 0; q < 3; q++) begin
                wr(ptrOff[2 * q], {word[11:0], q == 2 ? 18'h00001 : up | mask, 2'b11});
                wr(ptrOff[2 * q + 1], {word[11:0], q == 2 ? up | mask : 18'h00001, 2'b11});
            end
            rd(ptrOff[0], {base, up | mask, 2'b00});
            wr(12'h040, d1);
            chk("queue memory", {1'b0, d1}, {1'b0, mqp_queue_mem_inst.mem[{base, up | mask, 2'b00}]});
            wr(12'h044, d2);
            rd(12'h044, d2);
            for (int q = 0; q < 3; q++) begin
                rd(ptrOff[2 * q], {base, q == 2 ? 18'h00001 : up, 2'b00});
                rd(ptrOff[2 * q + 1], {base, q == 2 ? up : 18'h00001, 2'b00});
            end
        end
        // Bottom read option: equal pair reads all ones, unequal pair reads its value
        wr(12'h200, {base, 9'h000, 3'h0, 8'h02});
        wr(ptrOff[1], {12'h000, up, 2'b00});
        rd(ptrOff[1], 32'hFFFFFFFF);
        rd(ptrOff[3], {base, 18'h00001, 2'b00});
        // Queues disabled: port traffic dropped, no memory cycle, pointers kept
        wr(12'h200, {base, 9'h000, 3'h0, 8'h01});
        n0 = mqp_queue_mem_inst.nReq;
        wr(12'h040, d1);
        rd(12'h044, 32'hFFFFFFFF);
        chk("memory cycles", 33'(n0), 33'(mqp_queue_mem_inst.nReq));
        rd(ptrOff[0], {base, up, 2'b00});
        rd(ptrOff[1], {base, up, 2'b00});
        test_done();
    end
endmodule : mqp_msg_queue_pointer_regs_bench
